//--- design/supply_pkg.sv
// Package with state, carrier types and timing constants of the supply-fail and path control.
package supply_pkg;

  localparam int unsigned CLK_HZ = 50000000;
  localparam int unsigned RECOVER_WINDOW_US = 5000;
  localparam int unsigned RECOVER_CYCLES = RECOVER_WINDOW_US * (CLK_HZ / 1000000);
  localparam int unsigned RECOVER_W = 18;

  // Power states of the device.
  typedef enum logic [2:0] {
    ST_OFF,
    ST_WAIT_EN,
    ST_ACTIVE,
    ST_SUSPEND,
    ST_RECOVERY,
    ST_POWERDOWN
  } pwr_state_t;

  // Analog comparator results toward the core.
  typedef struct packed {
    logic above_uvlo;
    logic above_uvlo_hys;
    logic above_2v55;
    logic above_2v5;
    logic fast_ramp;
    logic above_internal_regulator_output;
  } bias_cmp_t;

  // Strap range index from the resistor comparator ladder, 0 to 7.
  localparam int unsigned STRAP_W = 3;
  localparam logic [5:0] BUCK3_CODE_R1 = 6'h12;
  localparam logic [5:0] BUCK3_CODE_R2 = 6'h18;
  localparam logic [5:0] BUCK3_CODE_R3 = 6'h1f;
  localparam logic [5:0] BUCK3_CODE_R4 = 6'h3d;
  localparam logic [5:0] BB_CODE_R4 = 6'h01;
  localparam logic [5:0] BB_CODE_R5 = 6'h07;
  localparam logic [5:0] BB_CODE_R6 = 6'h0d;
  localparam logic [5:0] BB_CODE_R7 = 6'h14;

  // Decoded power-up defaults of the two converters.
  typedef struct packed {
    logic buck3_use_code;
    logic [5:0] buck3_code;
    logic bb_use_code;
    logic [5:0] bb_code;
  } strap_dflt_t;

  localparam int unsigned NUM_LS = 3;
endpackage

//--- design/strap_decoder.sv
// Module that samples the strap range once and holds the decoded converter defaults.
module strap_decoder (
  input wire logic clk,
  input wire logic rst,
  input wire logic sample,
  input wire logic [supply_pkg::STRAP_W-1:0] strap_range,
  output supply_pkg::strap_dflt_t dflt_r,
  output logic done_r
);

  supply_pkg::strap_dflt_t dflt_nxt;
  supply_pkg::strap_dflt_t decoded;
  logic done_nxt;

  // Range to code lookup; unlisted ranges keep the programmed default.
  always_comb begin
    decoded = '0;
    unique case (strap_range)
      3'h1: begin
        decoded.buck3_use_code = 1'b1; // see [R12]
        decoded.buck3_code = supply_pkg::BUCK3_CODE_R1;
      end
      3'h2: begin
        decoded.buck3_use_code = 1'b1; // see [R12]
        decoded.buck3_code = supply_pkg::BUCK3_CODE_R2;
      end
      3'h3: begin
        decoded.buck3_use_code = 1'b1; // see [R12]
        decoded.buck3_code = supply_pkg::BUCK3_CODE_R3;
      end
      3'h4: begin
        decoded.buck3_use_code = 1'b1; // see [R12]
        decoded.buck3_code = supply_pkg::BUCK3_CODE_R4;
        decoded.bb_use_code = 1'b1; // see [R13]
        decoded.bb_code = supply_pkg::BB_CODE_R4;
      end
      3'h5: begin
        decoded.bb_use_code = 1'b1; // see [R13]
        decoded.bb_code = supply_pkg::BB_CODE_R5;
      end
      3'h6: begin
        decoded.bb_use_code = 1'b1; // see [R13]
        decoded.bb_code = supply_pkg::BB_CODE_R6;
      end
      3'h7: begin
        decoded.bb_use_code = 1'b1; // see [R13]
        decoded.bb_code = supply_pkg::BB_CODE_R7;
      end
      default: begin
        decoded = '0;
      end
    endcase
  end

  // Capture only the first sample after reset and hold it.
  always_comb begin
    dflt_nxt = dflt_r;
    done_nxt = done_r;
    if (sample && !done_r) begin
      dflt_nxt = decoded; // see [R14]
      done_nxt = 1'b1;
    end
  end

  // Registers of the held defaults.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      dflt_r <= '0;
      done_r <= 1'b0;
    end else begin
      dflt_r <= dflt_nxt;
      done_r <= done_nxt;
    end
  end

endmodule

//--- design/supply_fail_and_path_control.sv
// Top module of the supply-fail, load-shed and backup power-path control.
//
// Functional notes
// [R1] Fast ramp: enable at base threshold; dips above 2.55 V tolerated 5 ms.
// [R2] Slow ramp: enable at threshold plus hysteresis; dips above 2.5 V tolerated 5 ms.
// [R3] Below 2.5 V: reset core, turn off all rails, discharge them at once.
// [R4] Power-fail trip changes nothing unless its configuration bits are set.
// [R5] Per-switch option turns the load switch off on a power-fail trip.
// [R6] With the power-down enable bit set, a trip starts the power-down sequence.
// [R7] No interrupt or status bit shows the power-fail comparator.
// [R8] In wait, active, suspend and recovery, backup path takes the main backup input.
// [R9] In off, path picks the higher input with 150 mV hysteresis.
// [R10] Bias below lockout: shut down all rails and enter off; the code enters power-down, and off on powerdown_done or bias below regulator level.
// [R11] Bias below regulator level before power-down ends: reset, off, main backup input.
// [R12] Strap decode gives third buck code 0x12, 0x18, 0x1F, 0x3D or default.
// [R13] Strap decode gives buck-boost code 0x01, 0x07, 0x0D, 0x14 or default.
// [R14] Strap sampled once at power-up before converters enable, held until reset.
module supply_fail_and_path_control (
  input wire logic clk,
  input wire logic rst,
  input supply_pkg::bias_cmp_t bias_cmp,
  input wire logic power_fail_input,
  input wire logic pfail_triggers_powerdown,
  input wire logic [supply_pkg::NUM_LS-1:0] ls_shed_on_pfail,
  input wire logic [supply_pkg::NUM_LS-1:0] ls_enable_set,
  input wire logic power_on_request,
  input wire logic suspend_request,
  input wire logic recovery_request,
  input wire logic powerdown_done,
  input wire logic coin_above_main_hys,
  input wire logic main_above_coin_hys,
  input wire logic [supply_pkg::STRAP_W-1:0] strap_range,
  output logic rails_enable_r,
  output logic rails_discharge_r,
  output logic powerdown_start_r,
  output logic core_reset_r,
  output logic [supply_pkg::NUM_LS-1:0] ls_on_r,
  output logic backup_from_coin_r,
  output supply_pkg::pwr_state_t state_r,
  output supply_pkg::strap_dflt_t strap_dflt_r,
  output logic strap_valid_r
);

  supply_pkg::pwr_state_t state_nxt;
  logic rails_enable_nxt;
  logic rails_discharge_nxt;
  logic powerdown_start_nxt;
  logic core_reset_nxt;
  logic [supply_pkg::NUM_LS-1:0] ls_on_nxt;
  logic backup_from_coin_nxt;
  logic [supply_pkg::RECOVER_W-1:0] dip_cnt_r;
  logic [supply_pkg::RECOVER_W-1:0] dip_cnt_nxt;
  logic dip_r;
  logic dip_nxt;
  logic fast_mode_r;
  logic fast_mode_nxt;
  logic pfail_d_r;
  logic pfail_d_nxt;
  logic pfail_trip;
  logic recover_ok;
  logic dip_floor_ok;
  logic powered;
  logic strap_sample;

  // The trip is an edge so a held comparator acts once; the comparator only steers logic.
  assign pfail_trip = power_fail_input && !pfail_d_r; // see [R7]
  assign powered = (state_r != supply_pkg::ST_OFF);
  // Recovery level and dip floor follow the ramp kind seen at power-up.
  assign recover_ok = fast_mode_r ? bias_cmp.above_uvlo : bias_cmp.above_uvlo_hys; // see [R1]
  assign dip_floor_ok = fast_mode_r ? bias_cmp.above_2v55 : bias_cmp.above_2v5; // see [R2]
  // Strap is captured in the wait state before any converter turns on.
  assign strap_sample = (state_r == supply_pkg::ST_WAIT_EN); // see [R14]

  strap_decoder u_strap (
    .clk(clk),
    .rst(rst),
    .sample(strap_sample),
    .strap_range(strap_range),
    .dflt_r(strap_dflt_r),
    .done_r(strap_valid_r)
  );

  // Main state, lockout timing, power-fail actions and path choice.
  always_comb begin
    state_nxt = state_r;
    rails_enable_nxt = rails_enable_r;
    rails_discharge_nxt = 1'b0;
    powerdown_start_nxt = 1'b0;
    core_reset_nxt = 1'b0;
    ls_on_nxt = ls_on_r | ls_enable_set;
    backup_from_coin_nxt = backup_from_coin_r;
    dip_cnt_nxt = dip_cnt_r;
    dip_nxt = dip_r;
    fast_mode_nxt = fast_mode_r;
    pfail_d_nxt = power_fail_input;
    unique case (state_r)
      supply_pkg::ST_OFF: begin
        rails_enable_nxt = 1'b0;
        ls_on_nxt = '0;
        // Choose the higher input with hysteresis while off.
        if (!backup_from_coin_r && coin_above_main_hys) begin
          backup_from_coin_nxt = 1'b1; // see [R9]
        end else if (backup_from_coin_r && main_above_coin_hys) begin
          backup_from_coin_nxt = 1'b0; // see [R9]
        end
        // Enable level depends on the ramp rate.
        if (bias_cmp.fast_ramp && bias_cmp.above_uvlo) begin
          fast_mode_nxt = 1'b1; // see [R1]
          state_nxt = supply_pkg::ST_WAIT_EN;
        end else if (bias_cmp.above_uvlo_hys) begin
          fast_mode_nxt = 1'b0; // see [R2]
          state_nxt = supply_pkg::ST_WAIT_EN;
        end
      end
      supply_pkg::ST_WAIT_EN: begin
        if (power_on_request && strap_valid_r) begin
          rails_enable_nxt = 1'b1;
          state_nxt = supply_pkg::ST_ACTIVE;
        end
      end
      supply_pkg::ST_ACTIVE: begin
        if (suspend_request) begin
          state_nxt = supply_pkg::ST_SUSPEND;
        end else if (recovery_request) begin
          state_nxt = supply_pkg::ST_RECOVERY;
        end
      end
      supply_pkg::ST_SUSPEND: begin
        if (!suspend_request) begin
          state_nxt = supply_pkg::ST_ACTIVE;
        end
      end
      supply_pkg::ST_RECOVERY: begin
        rails_enable_nxt = 1'b0;
        if (powerdown_done) begin
          state_nxt = supply_pkg::ST_WAIT_EN;
        end
      end
      supply_pkg::ST_POWERDOWN: begin
        rails_enable_nxt = 1'b0;
        if (powerdown_done) begin
          state_nxt = supply_pkg::ST_OFF;
        end
      end
      default: begin
        state_nxt = supply_pkg::ST_OFF;
      end
    endcase

    // Powered states take the main backup input from the second powered cycle on.
    if (powered) begin
      backup_from_coin_nxt = 1'b0; // see [R8]
    end

    // Power-fail actions only when enabled by their configuration bits.
    if (powered && pfail_trip) begin
      ls_on_nxt = ls_on_nxt & ~ls_shed_on_pfail; // see [R4] [R5]
      if (pfail_triggers_powerdown && state_r != supply_pkg::ST_POWERDOWN) begin
        powerdown_start_nxt = 1'b1; // see [R6]
        state_nxt = supply_pkg::ST_POWERDOWN;
      end
    end

    // Lockout dip tracking: a dip must recover within the window.
    if (powered && state_r != supply_pkg::ST_POWERDOWN) begin
      if (!dip_r && !bias_cmp.above_uvlo) begin
        dip_nxt = 1'b1;
        dip_cnt_nxt = '0;
      end else if (dip_r) begin
        if (recover_ok) begin
          dip_nxt = 1'b0; // see [R1] [R2]
        end else if (!dip_floor_ok ||
                     dip_cnt_r == supply_pkg::RECOVER_W'(supply_pkg::RECOVER_CYCLES - 1)) begin
          // Window expired or floor crossed: shut down and enter power-down.
          dip_nxt = 1'b0;
          rails_enable_nxt = 1'b0;
          powerdown_start_nxt = 1'b1; // see [R10]
          ls_on_nxt = '0;
          state_nxt = supply_pkg::ST_POWERDOWN;
        end else begin
          dip_cnt_nxt = dip_cnt_r + 1'b1;
        end
      end
    end else begin
      dip_nxt = 1'b0;
    end

    // Bias below regulator level while powering down forces off at once.
    if (state_r == supply_pkg::ST_POWERDOWN && !bias_cmp.above_internal_regulator_output) begin
      core_reset_nxt = 1'b1; // see [R11]
      state_nxt = supply_pkg::ST_OFF;
      backup_from_coin_nxt = 1'b0; // see [R11]
    end

    // Hard floor: reset the core, drop and discharge every rail at once.
    if (powered && !bias_cmp.above_2v5) begin
      core_reset_nxt = 1'b1; // see [R3]
      rails_enable_nxt = 1'b0;
      rails_discharge_nxt = 1'b1; // see [R3]
      ls_on_nxt = '0;
      dip_nxt = 1'b0;
      state_nxt = supply_pkg::ST_OFF;
      backup_from_coin_nxt = 1'b0;
    end

    // Disabled rails discharge whenever they are off and the next state is off.
    if (!rails_enable_nxt && state_nxt == supply_pkg::ST_OFF) begin
      rails_discharge_nxt = 1'b1;
    end
  end

  // State registers.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_r <= supply_pkg::ST_OFF;
      rails_enable_r <= 1'b0;
      rails_discharge_r <= 1'b1;
      powerdown_start_r <= 1'b0;
      core_reset_r <= 1'b0;
      ls_on_r <= '0;
      backup_from_coin_r <= 1'b0;
      dip_cnt_r <= '0;
      dip_r <= 1'b0;
      fast_mode_r <= 1'b0;
      pfail_d_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      rails_enable_r <= rails_enable_nxt;
      rails_discharge_r <= rails_discharge_nxt;
      powerdown_start_r <= powerdown_start_nxt;
      core_reset_r <= core_reset_nxt;
      ls_on_r <= ls_on_nxt;
      backup_from_coin_r <= backup_from_coin_nxt;
      dip_cnt_r <= dip_cnt_nxt;
      dip_r <= dip_nxt;
      fast_mode_r <= fast_mode_nxt;
      pfail_d_r <= pfail_d_nxt;
    end
  end

endmodule

//--- bench/supply_env.sv
// Model of the supply environment: bias, coin cell and main backup comparators.
module supply_env #(
  parameter int UVLO_MV = 3000,
  parameter int HYS_MV = 200
) (
  input wire logic [15:0] bias_mv,
  input wire logic [15:0] coin_mv,
  input wire logic [15:0] main_mv,
  input wire logic fast,
  output supply_pkg::bias_cmp_t cmp,
  output logic coin_hi,
  output logic main_hi
);
  timeunit 1ns;
  timeprecision 1ps;
  // Comparator levels follow the supply voltages at once.
  always_comb begin
    cmp.above_uvlo = bias_mv > UVLO_MV;
    cmp.above_uvlo_hys = bias_mv > UVLO_MV + HYS_MV;
    cmp.above_2v55 = bias_mv > 2550;
    cmp.above_2v5 = bias_mv > 2500;
    cmp.fast_ramp = fast;
    cmp.above_internal_regulator_output = bias_mv > 2500;
    coin_hi = coin_mv > main_mv + 150;
    main_hi = main_mv > coin_mv + 150;
  end
endmodule

//--- bench/supply_props.sv
// Checker of the supply-fail and path control outputs.
module supply_props (
  input wire logic clk,
  input wire logic rst,
  input supply_pkg::bias_cmp_t bias_cmp,
  input wire logic power_fail_input,
  input wire logic pfail_triggers_powerdown,
  input wire logic [supply_pkg::NUM_LS-1:0] ls_shed_on_pfail,
  input wire logic [supply_pkg::NUM_LS-1:0] ls_enable_set,
  input wire logic coin_above_main_hys,
  input wire logic main_above_coin_hys,
  input wire logic rails_enable_r,
  input wire logic rails_discharge_r,
  input wire logic powerdown_start_r,
  input wire logic core_reset_r,
  input wire logic [supply_pkg::NUM_LS-1:0] ls_on_r,
  input wire logic backup_from_coin_r,
  input supply_pkg::pwr_state_t state_r,
  input supply_pkg::strap_dflt_t strap_dflt_r,
  input wire logic strap_valid_r
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  // A lost core supply resets, turns the rails off and discharges them next cycle.
  a_floor_loss_off: assert property (state_r != supply_pkg::ST_OFF && !bias_cmp.above_2v5 |=>
    core_reset_r && state_r == supply_pkg::ST_OFF && !rails_enable_r && rails_discharge_r)
    else $error("floor loss not handled");
  a_active_main_path: assert property (state_r inside {supply_pkg::ST_ACTIVE,
    supply_pkg::ST_SUSPEND, supply_pkg::ST_RECOVERY} |-> !backup_from_coin_r)
    else $error("coin cell used while powered");
  a_off_coin_pick: assert property (state_r == supply_pkg::ST_OFF && coin_above_main_hys
    ##1 state_r == supply_pkg::ST_OFF |-> backup_from_coin_r)
    else $error("higher coin cell not chosen");
  a_off_main_pick: assert property (state_r == supply_pkg::ST_OFF && main_above_coin_hys
    ##1 state_r == supply_pkg::ST_OFF |-> !backup_from_coin_r)
    else $error("higher main input not chosen");
  a_trip_powerdown: assert property (state_r == supply_pkg::ST_ACTIVE &&
    $rose(power_fail_input) && pfail_triggers_powerdown |=> powerdown_start_r)
    else $error("trip did not start power-down");
  a_trip_quiet: assert property ($rose(power_fail_input) && !pfail_triggers_powerdown &&
    bias_cmp.above_uvlo && bias_cmp.above_2v5 |=> !powerdown_start_r)
    else $error("trip started power-down unasked");
  a_shed_switch: assert property (state_r == supply_pkg::ST_ACTIVE &&
    $rose(power_fail_input) && ls_enable_set == 3'h0 |=> (ls_on_r & $past(ls_shed_on_pfail)) == 3'h0)
    else $error("load switch not shed");
  a_keep_switch: assert property ($rose(power_fail_input) && ls_enable_set == 3'h0 &&
    !pfail_triggers_powerdown && state_r == supply_pkg::ST_ACTIVE |=>
    (ls_on_r & ~$past(ls_shed_on_pfail)) == ($past(ls_on_r) & ~$past(ls_shed_on_pfail)))
    else $error("unshed switch changed on trip");
  a_strap_held: assert property (strap_valid_r && $past(strap_valid_r) |->
    $stable(strap_dflt_r)) else $error("strap defaults changed");
endmodule
bind supply_fail_and_path_control supply_props i_supply_props (.clk, .rst, .bias_cmp,
  .power_fail_input, .pfail_triggers_powerdown, .ls_shed_on_pfail, .ls_enable_set,
  .coin_above_main_hys, .main_above_coin_hys, .rails_enable_r, .rails_discharge_r,
  .powerdown_start_r, .core_reset_r, .ls_on_r, .backup_from_coin_r, .state_r,
  .strap_dflt_r, .strap_valid_r);

//--- bench/test_supply_fail_and_path_control.sv
// Self-checking bench of the supply-fail and path control.
module test_supply_fail_and_path_control;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic power_fail_input = 1'b0;
  logic pfail_triggers_powerdown = 1'b0;
  logic [2:0] ls_shed_on_pfail = 3'h0;
  logic [2:0] ls_enable_set = 3'h0;
  logic power_on_request = 1'b0;
  logic suspend_request = 1'b0;
  logic recovery_request = 1'b0;
  logic powerdown_done = 1'b0;
  logic fast = 1'b0;
  logic [2:0] strap_range = 3'h0;
  logic [15:0] bias_mv = 16'h0;
  logic [15:0] coin_mv = 16'h0;
  logic [15:0] main_mv = 16'h0;
  supply_pkg::bias_cmp_t bias_cmp;
  logic coin_above_main_hys;
  logic main_above_coin_hys;
  logic rails_enable_r;
  logic rails_discharge_r;
  logic powerdown_start_r;
  logic core_reset_r;
  logic [2:0] ls_on_r;
  logic backup_from_coin_r;
  supply_pkg::pwr_state_t state_r;
  supply_pkg::strap_dflt_t strap_dflt_r;
  logic strap_valid_r;
  int miscompares = 0;
  int checked = 0;
  int cycles = 0;
  int seed = 94;
  int sel;
  int b3 [8] = '{0, 'h12, 'h18, 'h1f, 'h3d, 0, 0, 0};
  int bb [8] = '{0, 0, 0, 0, 'h01, 'h07, 'h0d, 'h14};
  supply_env i_supply_env (.bias_mv, .coin_mv, .main_mv, .fast, .cmp(bias_cmp),
    .coin_hi(coin_above_main_hys), .main_hi(main_above_coin_hys));
  supply_fail_and_path_control i_supply_fail_and_path_control (.clk, .rst, .bias_cmp,
    .power_fail_input, .pfail_triggers_powerdown, .ls_shed_on_pfail, .ls_enable_set,
    .power_on_request, .suspend_request, .recovery_request, .powerdown_done,
    .coin_above_main_hys, .main_above_coin_hys, .strap_range, .rails_enable_r,
    .rails_discharge_r, .powerdown_start_r, .core_reset_r, .ls_on_r, .backup_from_coin_r,
    .state_r, .strap_dflt_r, .strap_valid_r);
  // Clock of 20 ns and a cycle ceiling against hangs.
  always #10 clk = ~clk;
  always @(posedge clk) begin
    cycles++;
    if (cycles == 5000) begin
      miscompares++;
      results();
    end
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic results;
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task automatic wait_st(input supply_pkg::pwr_state_t s);
    int n;
    n = 0;
    while (state_r !== s && n < 20) begin
      @(negedge clk);
      n++;
    end
    check(state_r, s);
  endtask
  // Resets, ramps the bias in two steps and powers up with the given strap range.
  task automatic power_up(input int r);
    rst = 1'b1;
    bias_mv = 16'h0;
    power_on_request = 1'b0;
    fast = 1'($random(seed));
    repeat (10) @(negedge clk);
    strap_range = 3'(r);
    rst = 1'b0;
    check(rails_discharge_r, 1'b1);
    check(rails_enable_r, 1'b0);
    bias_mv = 16'd3100;
    repeat (4) @(negedge clk);
    check(state_r != supply_pkg::ST_OFF, fast);
    bias_mv = 16'd3500;
    wait_st(supply_pkg::ST_WAIT_EN);
    @(negedge clk);
    check(backup_from_coin_r, 1'b0);
    check(strap_valid_r, 1'b1);
    check(strap_dflt_r.buck3_use_code, b3[r] != 0);
    if (b3[r] != 0) check(strap_dflt_r.buck3_code, b3[r]);
    check(strap_dflt_r.bb_use_code, bb[r] != 0);
    if (bb[r] != 0) check(strap_dflt_r.bb_code, bb[r]);
    power_on_request = 1'b1;
    wait_st(supply_pkg::ST_ACTIVE);
    check(rails_enable_r, 1'b1);
  endtask
  // Main sequence: strap table, load shed, power-fail, floor loss, off-state path.
  initial begin
    for (int r = 0; r < 8; r++) power_up(r);
    $display("test strap done");
    ls_enable_set = 3'h7;
    ls_shed_on_pfail = 3'($random(seed));
    @(negedge clk);
    ls_enable_set = 3'h0;
    @(negedge clk);
    check(ls_on_r, 3'h7);
    power_fail_input = 1'b1;
    repeat (2) @(negedge clk);
    check(ls_on_r, 3'h7 & ~ls_shed_on_pfail);
    check(state_r, supply_pkg::ST_ACTIVE);
    power_fail_input = 1'b0;
    pfail_triggers_powerdown = 1'b1;
    @(negedge clk);
    power_fail_input = 1'b1;
    @(negedge clk);
    check(powerdown_start_r, 1'b1);
    $display("test power-fail done");
    power_fail_input = 1'b0;
    pfail_triggers_powerdown = 1'b0;
    // Suspend and recovery keep the main backup input; recovery drops the rails.
    power_up(5);
    suspend_request = 1'b1;
    repeat (2) @(negedge clk);
    check(state_r, supply_pkg::ST_SUSPEND);
    check(backup_from_coin_r, 1'b0);
    suspend_request = 1'b0;
    repeat (2) @(negedge clk);
    check(state_r, supply_pkg::ST_ACTIVE);
    recovery_request = 1'b1;
    @(negedge clk);
    recovery_request = 1'b0;
    @(negedge clk);
    check(state_r, supply_pkg::ST_RECOVERY);
    check({rails_enable_r, backup_from_coin_r}, 2'h0);
    powerdown_done = 1'b1;
    @(negedge clk);
    powerdown_done = 1'b0;
    wait_st(supply_pkg::ST_ACTIVE);
    // A short dip that recovers keeps the device active.
    bias_mv = 16'd2900;
    repeat (3) @(negedge clk);
    check(state_r, supply_pkg::ST_ACTIVE);
    bias_mv = 16'd3500;
    repeat (3) @(negedge clk);
    check(state_r, supply_pkg::ST_ACTIVE);
    // A dip between 2.5 V and 2.55 V crosses the floor only in fast mode.
    bias_mv = 16'd2520;
    repeat (2) @(negedge clk);
    check(powerdown_start_r, fast);
    powerdown_done = 1'b1;
    @(negedge clk);
    powerdown_done = 1'b0;
    check(state_r, fast ? supply_pkg::ST_OFF : supply_pkg::ST_ACTIVE);
    check(rails_enable_r, !fast);
    $display("test dip done");
    power_up(3);
    bias_mv = 16'd2400;
    @(negedge clk);
    check({core_reset_r, rails_enable_r, rails_discharge_r}, 3'h5);
    check(state_r, supply_pkg::ST_OFF);
    @(negedge clk);
    check(core_reset_r, 1'b0);
    $display("test floor loss done");
    main_mv = 16'd3000;
    sel = 0;
    for (int i = 0; i < 16; i++) begin
      coin_mv = 16'(2700 + ($random(seed) & 'h25f));
      if (coin_mv > main_mv + 150) sel = 1;
      else if (main_mv > coin_mv + 150) sel = 0;
      repeat (2) @(negedge clk);
      check(backup_from_coin_r, sel);
    end
    $display("test backup path done");
    results();
  end
endmodule
